//--- hw/rtccal_pkg.sv
// constants for the rtc calibration output and calendar block
package rtccal_pkg;

    // core clock
    localparam int unsigned CLK_HZ = 50_000_000;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_DATE = 8'h06;
    localparam logic [7:0] IDX_MONTH = 8'h07;
    localparam logic [7:0] IDX_YEAR = 8'h08;
    localparam logic [7:0] IDX_PULSE_CFG = 8'h0f;
    localparam logic [7:0] IDX_PULSE_STATUS = 8'h10;

    // pulse output configuration fields
    localparam int unsigned BIT_SLEEP_ROUTE = 7;
    localparam int unsigned BIT_OUT_EN = 6;
    localparam int unsigned POS_FREQ_SEL = 4;
    localparam int unsigned BIT_ROUTE_A = 3;
    localparam int unsigned BIT_ROUTE_B = 2;
    localparam int unsigned BIT_ROUTE_C = 1;
    localparam int unsigned BIT_ROUTE_D = 0;
    localparam logic [7:0] PULSE_CFG_RESET = 8'h00;

    // pulse status fields
    localparam int unsigned POS_STATUS_PINS = 0;
    localparam int unsigned BIT_STATUS_SLEEP = 4;
    localparam int unsigned BIT_STATUS_LEVEL = 5;

    // frequency select codes
    localparam logic [1:0] PULSE_FREQ_SELECT_1HZ = 2'h0;
    localparam logic [1:0] PULSE_FREQ_SELECT_512HZ = 2'h1;
    localparam logic [1:0] PULSE_FREQ_SELECT_500HZ = 2'h2;
    localparam logic [1:0] PULSE_FREQ_SELECT_16KHZ = 2'h3;

    // output frequencies in hertz
    localparam int unsigned FREQ_1HZ = 1;
    localparam int unsigned FREQ_512HZ = 512;
    localparam int unsigned FREQ_500HZ = 500;
    localparam int unsigned FREQ_16KHZ = 16_000;

    // half periods in core cycles, rounded down
    localparam int unsigned HALF_1HZ = CLK_HZ / (2 * FREQ_1HZ);
    localparam int unsigned HALF_512HZ = CLK_HZ / (2 * FREQ_512HZ);
    localparam int unsigned HALF_500HZ = CLK_HZ / (2 * FREQ_500HZ);
    localparam int unsigned HALF_16KHZ = CLK_HZ / (2 * FREQ_16KHZ);
    localparam int unsigned CNT_W = 25;

    // calendar reset values and limits
    localparam logic [7:0] DATE_RESET = 8'h01;
    localparam logic [7:0] MONTH_RESET = 8'h01;
    localparam logic [7:0] YEAR_RESET = 8'h00;
    localparam logic [7:0] MONTH_LAST = 8'h0c;
    localparam logic [7:0] LEAP_FIRST = 8'h04;
    localparam logic [7:0] LEAP_LAST = 8'h60;
    localparam logic [7:0] DAYS_28 = 8'h1c;
    localparam logic [7:0] DAYS_29 = 8'h1d;
    localparam logic [7:0] DAYS_30 = 8'h1e;
    localparam logic [7:0] DAYS_31 = 8'h1f;

endpackage

//--- hw/rtccal_pulse_gen.sv
// square wave generator for the calibration pulse
`timescale 1ns/100ps
module rtccal_pulse_gen #(
    parameter int unsigned HALF_1HZ = rtccal_pkg::HALF_1HZ,
    parameter int unsigned HALF_512HZ = rtccal_pkg::HALF_512HZ,
    parameter int unsigned HALF_500HZ = rtccal_pkg::HALF_500HZ
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [1:0] freq_sel,
    // output
    output logic level
);

    typedef struct packed {
        logic [rtccal_pkg::CNT_W-1:0] cnt;
        logic level;
        logic [1:0] sel;
    } rtccal_gen_t;

    rtccal_gen_t st;
    rtccal_gen_t next_st;

    function automatic logic [rtccal_pkg::CNT_W-1:0] half_count(input logic [1:0] sel);
        case (sel)
            rtccal_pkg::PULSE_FREQ_SELECT_1HZ: half_count = rtccal_pkg::CNT_W'(HALF_1HZ);
            rtccal_pkg::PULSE_FREQ_SELECT_512HZ: half_count = rtccal_pkg::CNT_W'(HALF_512HZ);
            rtccal_pkg::PULSE_FREQ_SELECT_500HZ: half_count = rtccal_pkg::CNT_W'(HALF_500HZ);
            default: half_count = rtccal_pkg::CNT_W'(rtccal_pkg::HALF_16KHZ);
        endcase
    endfunction

    always_comb
    begin
        next_st = st;
        next_st.sel = freq_sel;
        // restart on a new rate so the first period is already exact
        if (!run || (freq_sel != st.sel))
        begin
            next_st.cnt = '0;
            next_st.level = 1'b0;
        end
        else if (st.cnt >= half_count(st.sel) - 1'b1)
        begin
            next_st.cnt = '0;
            next_st.level = ~st.level;
        end
        else
        begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level = st.level;

endmodule

//--- hw/rtccal_top.sv
// calibration pulse output routing and calendar rollover with apb registers
//
// Functional notes
// - in the deepest power-saving mode only pin d may carry the pulse, and only with sleep route and enable set.
// - the output enable gates the pulse, which then appears on every routed pin outside the deepest power-saving mode.
// - frequency select picks 1 Hz, 512 Hz, 500 Hz or 16 kHz.
// - route bit 3 with enable drives pin a.
// - route bit 2 with enable drives pin b.
// - route bit 1 with enable drives pin c.
// - route bit 0 with enable drives pin d.
// - the pulse configuration register resets to zero.
// - the calendar keeps a full date with leap years.
// - months 1, 3, 5, 7, 8, 10 and 12 roll over after day 31.
// - months 4, 6, 9 and 11 roll over after day 30.
// - february rolls over after day 28, or 29 in a leap year.
// - years 4 to 96 in steps of four are leap years.
// - past the month length the date returns to 1 and the month advances.
// - the month starts at 1, wraps from 12 to 1 and then advances the year.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module rtccal_top #(
    parameter int unsigned HALF_1HZ = rtccal_pkg::HALF_1HZ,
    parameter int unsigned HALF_512HZ = rtccal_pkg::HALF_512HZ,
    parameter int unsigned HALF_500HZ = rtccal_pkg::HALF_500HZ
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // system state and time base
    input wire logic deepest_power_saving_mode,
    input wire logic day_tick,

    // calibration pins
    output logic calibration_pin_a,
    output logic calibration_pin_b,
    output logic calibration_pin_c,
    output logic calibration_pin_d
);

    typedef struct packed {
        logic [7:0] pulse_cfg;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
        logic [3:0] pins;
        logic [31:0] rdata;
        logic err;
    } rtccal_state_t;

    rtccal_state_t st;
    rtccal_state_t next_st;

    logic pulse_level;
    logic [1:0] pulse_freq_select;
    logic out_en;
    logic sleep_route;
    logic [3:0] route;
    logic setup_phase;
    logic access_phase;
    logic [5:0] word_idx;
    logic [7:0] reg_idx;
    logic [7:0] wr_byte;
    logic [7:0] status;
    logic [7:0] month_days;

    // leap years: nonzero multiples of four up to 96
    function automatic logic is_leap(input logic [7:0] year);
        is_leap = (year[1:0] == 2'b00) && (year >= rtccal_pkg::LEAP_FIRST)
            && (year <= rtccal_pkg::LEAP_LAST);
    endfunction

    // last day of a month
    function automatic logic [7:0] days_in(input logic [7:0] month, input logic [7:0] year);
        case (month)
            8'h02:
            begin
                if (is_leap(year))
                begin
                    days_in = rtccal_pkg::DAYS_29;
                end
                else
                begin
                    days_in = rtccal_pkg::DAYS_28;
                end
            end
            8'h04, 8'h06, 8'h09, 8'h0b:
            begin
                days_in = rtccal_pkg::DAYS_30;
            end
            default:
            begin
                days_in = rtccal_pkg::DAYS_31;
            end
        endcase
    endfunction

    // known register index or not
    function automatic logic is_mapped(input logic [7:0] idx);
        case (idx)
            rtccal_pkg::IDX_DATE,
            rtccal_pkg::IDX_MONTH,
            rtccal_pkg::IDX_YEAR,
            rtccal_pkg::IDX_PULSE_CFG,
            rtccal_pkg::IDX_PULSE_STATUS:
            begin
                is_mapped = 1'b1;
            end
            default:
            begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    // configuration fields
    assign sleep_route = st.pulse_cfg[rtccal_pkg::BIT_SLEEP_ROUTE];
    assign out_en = st.pulse_cfg[rtccal_pkg::BIT_OUT_EN];
    assign pulse_freq_select = st.pulse_cfg[rtccal_pkg::POS_FREQ_SEL +: 2];
    assign route = st.pulse_cfg[3:0];

    // apb decode
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign word_idx = paddr[7:2];
    assign reg_idx = {2'b00, word_idx};
    assign wr_byte = pwdata[7:0];

    // status view of the live pins and mode
    always_comb
    begin
        status = 8'h00;
        status[rtccal_pkg::POS_STATUS_PINS +: 4] = st.pins;
        status[rtccal_pkg::BIT_STATUS_SLEEP] = deepest_power_saving_mode;
        status[rtccal_pkg::BIT_STATUS_LEVEL] = pulse_level;
    end

    assign month_days = days_in(st.month, st.year);

    // divider only runs while the output enable is set, saving toggling
    rtccal_pulse_gen #(
        .HALF_1HZ(HALF_1HZ),
        .HALF_512HZ(HALF_512HZ),
        .HALF_500HZ(HALF_500HZ)
    ) u_pulse_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(out_en),
        .freq_sel(pulse_freq_select),
        .level(pulse_level)
    );

    always_comb
    begin
        next_st = st;

        // read data and error are captured in the setup cycle
        if (setup_phase)
        begin
            next_st.err = !is_mapped(reg_idx) || (paddr[1:0] != 2'b00);
            next_st.rdata = 32'h0000_0000;
            case (reg_idx)
                rtccal_pkg::IDX_DATE:
                begin
                    next_st.rdata[7:0] = st.date;
                end
                rtccal_pkg::IDX_MONTH:
                begin
                    next_st.rdata[7:0] = st.month;
                end
                rtccal_pkg::IDX_YEAR:
                begin
                    next_st.rdata[7:0] = st.year;
                end
                rtccal_pkg::IDX_PULSE_CFG:
                begin
                    next_st.rdata[7:0] = st.pulse_cfg;
                end
                rtccal_pkg::IDX_PULSE_STATUS:
                begin
                    next_st.rdata[7:0] = status;
                end
                default:
                begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end

        // daily calendar advance
        if (day_tick)
        begin
            if (st.date >= month_days)
            begin
                next_st.date = rtccal_pkg::DATE_RESET;
                if (st.month >= rtccal_pkg::MONTH_LAST)
                begin
                    next_st.month = rtccal_pkg::MONTH_RESET;
                    next_st.year = st.year + 8'h01;
                end
                else
                begin
                    next_st.month = st.month + 8'h01;
                end
            end
            else
            begin
                next_st.date = st.date + 8'h01;
            end
        end

        // software write lands after the tick so a set time is not skipped
        if (access_phase && pwrite && !st.err && pstrb[0])
        begin
            case (reg_idx)
                rtccal_pkg::IDX_DATE:
                begin
                    next_st.date = wr_byte;
                end
                rtccal_pkg::IDX_MONTH:
                begin
                    next_st.month = wr_byte;
                end
                rtccal_pkg::IDX_YEAR:
                begin
                    next_st.year = wr_byte;
                end
                rtccal_pkg::IDX_PULSE_CFG:
                begin
                    next_st.pulse_cfg = wr_byte;
                end
                default:
                begin
                    next_st.pulse_cfg = st.pulse_cfg;
                end
            endcase
        end

        // pin routing
        if (!out_en)
        begin
            next_st.pins = 4'h0;
        end
        else if (deepest_power_saving_mode)
        begin
            next_st.pins = 4'h0;
            next_st.pins[0] = sleep_route && pulse_level;
        end
        else
        begin
            next_st.pins[3] = route[rtccal_pkg::BIT_ROUTE_A] && pulse_level;
            next_st.pins[2] = route[rtccal_pkg::BIT_ROUTE_B] && pulse_level;
            next_st.pins[1] = route[rtccal_pkg::BIT_ROUTE_C] && pulse_level;
            next_st.pins[0] = route[rtccal_pkg::BIT_ROUTE_D] && pulse_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.pulse_cfg <= rtccal_pkg::PULSE_CFG_RESET;
            st.date <= rtccal_pkg::DATE_RESET;
            st.month <= rtccal_pkg::MONTH_RESET;
            st.year <= rtccal_pkg::YEAR_RESET;
            st.pins <= 4'h0;
            st.rdata <= 32'h0000_0000;
            st.err <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // one wait-free access cycle after setup
    assign pready = access_phase;
    assign pslverr = access_phase && st.err;
    assign prdata = st.rdata;

    assign calibration_pin_a = st.pins[3];
    assign calibration_pin_b = st.pins[2];
    assign calibration_pin_c = st.pins[1];
    assign calibration_pin_d = st.pins[0];

endmodule

//--- tb/rtccal_assertions.sv
// checker for pulse pin gating and apb answers
`timescale 1ns/100ps
module rtccal_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // mode and pins
    input wire logic deepest_power_saving_mode,
    input wire logic calibration_pin_a,
    input wire logic calibration_pin_b,
    input wire logic calibration_pin_c,
    input wire logic calibration_pin_d
);
    logic [7:0] cfg;
    logic dm;
    logic pa;
    logic pb;
    logic pc;
    logic pd;
    assign dm = deepest_power_saving_mode;
    assign pa = calibration_pin_a;
    assign pb = calibration_pin_b;
    assign pc = calibration_pin_c;
    assign pd = calibration_pin_d;
    // shadow of the config register, pins lag it by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg <= 8'h00;
        end
        else if (psel && penable && pwrite && pstrb[0] && paddr == 8'h3c)
        begin
            cfg <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_enable_gate:
        assert property ((!cfg[6]) [*2] |-> !(pa | pb | pc | pd))
        else $error("pin active while disabled");
    chk_route_a:
        assert property ((!cfg[3] || dm) [*2] |-> !pa)
        else $error("pin a active while unrouted");
    chk_route_b:
        assert property ((!cfg[2] || dm) [*2] |-> !pb)
        else $error("pin b active while unrouted");
    chk_route_c:
        assert property ((!cfg[1] || dm) [*2] |-> !pc)
        else $error("pin c active while unrouted");
    chk_route_d:
        assert property ((!dm && !cfg[0]) [*2] |-> !pd)
        else $error("pin d active while unrouted");
    chk_pins_match:
        assert property ((cfg[6] && cfg[3] && cfg[2] && !dm) [*2] |-> pa == pb)
        else $error("routed pins differ");
    chk_deep_others:
        assert property (dm [*2] |-> !(pa | pb | pc))
        else $error("pin a b or c active in deepest mode");
    chk_deep_pin_d:
        assert property ((dm && !(cfg[7] && cfg[6])) [*2] |-> !pd)
        else $error("pin d active in deepest mode");
    chk_reset_quiet:
        assert property ($rose(presetn) |-> !(pa | pb | pc | pd))
        else $error("pin active after reset");
    chk_ready_now:
        assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("access phase without ready");
    chk_misaligned_err:
        assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access without error");
endmodule

bind rtccal_top rtccal_assertions i_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
    .deepest_power_saving_mode, .calibration_pin_a, .calibration_pin_b,
    .calibration_pin_c, .calibration_pin_d);

//--- tb/rtccal_meter.sv
// frequency meter watching one calibration pin
`timescale 1ns/100ps
module rtccal_meter (
    // clock
    input wire logic pclk,
    // watched pin
    input wire logic pin,
    // last high width in cycles and count of falls
    output int width,
    output int falls
);
    int run = 0;
    initial
    begin
        width = 0;
        falls = 0;
    end
    always @(posedge pclk)
    begin
        if (pin)
        begin
            run <= run + 1;
        end
        else if (run != 0)
        begin
            width <= run;
            falls <= falls + 1;
            run <= 0;
        end
    end
endmodule

//--- tb/rtccal_top_tb.sv
// bench for the calibration pulse output and calendar
`timescale 1ns/100ps
module rtccal_top_tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic dm;
    logic tick;
    logic err;
    logic pready;
    logic pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [3:0] pstrb;
    logic [1:0] lo;
    wire logic [3:0] pin;
    logic [3:0] seen;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int width;
    int falls;
    int halves[4] = '{20, 10, 8, 1562};
    logic [7:0] years[5] = '{8'h04, 8'h60, 8'h00, 8'h64, 8'h0d};

    rtccal_top #(.HALF_1HZ(20), .HALF_512HZ(10), .HALF_500HZ(8)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .deepest_power_saving_mode(dm), .day_tick(tick),
        .calibration_pin_a(pin[3]), .calibration_pin_b(pin[2]),
        .calibration_pin_c(pin[1]), .calibration_pin_d(pin[0]));
    rtccal_meter i_meter (.pclk, .pin(pin[3]), .width, .falls);

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[5:0], lo};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // skip two cycles so the previous setting has left the pins
    task automatic watch(input logic [7:0] cfg, input logic [3:0] exp);
        apb(1'b1, rtccal_pkg::IDX_PULSE_CFG, cfg);
        seen = 4'h0;
        repeat (2) @(posedge pclk);
        repeat (40) @(posedge pclk) seen = seen | pin;
        check("pins", {28'h0, exp}, {28'h0, seen});
    endtask
    task automatic freq(input logic [1:0] code, input int half);
        int f0;
        apb(1'b1, rtccal_pkg::IDX_PULSE_CFG, {2'h1, code, 4'h8});
        f0 = falls;
        while (falls < f0 + 2) @(posedge pclk);
        check("half period", half, width);
    endtask
    function automatic logic [7:0] mlen(input logic [7:0] m, input logic [7:0] y);
        if (m == 8'h02)
        begin
            return (y >= 8'h04 && y <= 8'h60 && y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        end
        return (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0b) ? 8'h1e : 8'h1f;
    endfunction
    task automatic roll(input logic [7:0] m, input logic [7:0] y, input logic [7:0] d);
        logic [7:0] ed;
        logic [7:0] em;
        ed = (d >= mlen(m, y)) ? 8'h01 : d + 8'h01;
        em = (ed != 8'h01) ? m : (m == 8'h0c) ? 8'h01 : m + 8'h01;
        apb(1'b1, rtccal_pkg::IDX_DATE, d);
        apb(1'b1, rtccal_pkg::IDX_MONTH, m);
        apb(1'b1, rtccal_pkg::IDX_YEAR, y);
        @(posedge pclk);
        tick <= 1'b1;
        @(posedge pclk);
        tick <= 1'b0;
        apb(1'b0, rtccal_pkg::IDX_DATE, 8'h00);
        check("date", {24'h0, ed}, rd);
        apb(1'b0, rtccal_pkg::IDX_MONTH, 8'h00);
        check("month", {24'h0, em}, rd);
        apb(1'b0, rtccal_pkg::IDX_YEAR, 8'h00);
        check("year", {24'h0, (em < m) ? y + 8'h01 : y}, rd);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        lo = 2'h0;
        dm = 1'b0;
        tick = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rtccal_pkg::IDX_PULSE_CFG, 8'h00);
        check("cfg reset", 32'h0, rd);
        apb(1'b0, 8'h05, 8'h00);
        check("unmapped error", 32'h1, {31'h0, err});
        // misaligned write must be refused and leave the register alone
        lo = 2'h2;
        apb(1'b1, rtccal_pkg::IDX_PULSE_CFG, 8'h7f);
        lo = 2'h0;
        check("misaligned error", 32'h1, {31'h0, err});
        apb(1'b0, rtccal_pkg::IDX_PULSE_CFG, 8'h00);
        check("cfg kept", 32'h0, rd);
        apb(1'b1, rtccal_pkg::IDX_PULSE_CFG, 8'hff);
        apb(1'b0, rtccal_pkg::IDX_PULSE_CFG, 8'h00);
        check("cfg", 32'hff, rd);
        for (int i = 0; i < 4; i++) freq(i[1:0], halves[i]);
        watch(8'h1f, 4'h0);
        for (int i = 0; i < 4; i++) watch({4'h5, 4'h1 << i}, 4'h1 << i);
        watch(8'h5f, 4'hf);
        @(posedge pclk);
        dm <= 1'b1;
        watch(8'hdf, 4'h1);
        watch(8'hd0, 4'h1);
        watch(8'h5f, 4'h0);
        watch(8'h1f, 4'h0);
        apb(1'b0, rtccal_pkg::IDX_PULSE_STATUS, 8'h00);
        check("status", 32'h10, rd);
        @(posedge pclk);
        dm <= 1'b0;
        for (int m = 1; m <= 12; m++)
        begin
            roll(m[7:0], 8'h05, mlen(m[7:0], 8'h05));
            roll(m[7:0], 8'h05, mlen(m[7:0], 8'h05) - 8'h01);
        end
        for (int i = 0; i < 5; i++) roll(8'h02, years[i], 8'h1c);
        roll(8'h02, 8'h60, 8'h1d);
        close_out();
    end
endmodule
